/* File: pkg/rit_consts.svh */
/*
  Constants of the reload interval timer: register selects, control bit
  positions, counter limits and prescaler figures.
  Assumes it is included by bare name wherever a number is needed.
*/
`ifndef RIT_CONSTS_SVH
`define RIT_CONSTS_SVH

// peripheral register selects (value of the Y' pointer)
`define RIT_SEL_CTRL 4'h3
`define RIT_SEL_RELOAD 4'h4

// control register bit positions
`define RIT_CTRL_START 0
`define RIT_CTRL_REPEAT 1
`define RIT_CTRL_HALT 2
`define RIT_CTRL_FLAG 3

// counter limits
`define RIT_CNT_MAX 8'hFF
`define RIT_CNT_ZERO 8'h00
`define RIT_CNT_ONE 8'h01
`define RIT_NIB_ZERO 4'h0

// prescaler: instruction rate is the clock divided by six
`define RIT_INST_LAST 3'h5
`define RIT_INST_ZERO 3'h0
`define RIT_INST_ONE 3'h1
`define RIT_CHAIN_W 12
`define RIT_CHAIN_ZERO 12'h000
`define RIT_CHAIN_ONE 12'h001
`define RIT_DIV_LOG2_DEF 1

`endif

/* File: pkg/rit_pkg.sv */
/*
  Types of the reload interval timer.
  Assumes rit_consts.svh for the numbers used beside these types.
*/
package rit_pkg;

  typedef enum logic [0:0] {
    RIT_ST_IDLE = 1'b0,
    RIT_ST_COUNT = 1'b1
  } rit_state_e;

  typedef logic [7:0] rit_count_t;
  typedef logic [3:0] rit_nib_t;

endpackage : rit_pkg

/* File: pkg/rit_pre_if.sv */
/*
  Link between the timer core and its prescaler: halt request out,
  timer tick and serial shift tick back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface rit_pre_if;
  logic halt;
  logic tick;
  logic sio_tick;

  modport ctrl (output halt, input tick, input sio_tick);
  modport gen (input halt, output tick, output sio_tick);
endinterface : rit_pre_if

`default_nettype wire

/* File: design/rit_prescaler.sv */
/*
  Prescaler: divides the clock by six to the instruction rate, then by a
  build-time power of two, giving the timer tick and the serial shift tick.
  Assumes halt comes from a register on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rit_consts.svh"

module rit_prescaler #(
  parameter int DIV_LOG2 = `RIT_DIV_LOG2_DEF
) (
  input wire logic clk,
  input wire logic reset,
  rit_pre_if.gen pre
);

  localparam logic [`RIT_CHAIN_W-1:0] MASK = `RIT_CHAIN_W'((1 << DIV_LOG2) - 1);

  logic [2:0] inst_cnt_reg;
  logic [`RIT_CHAIN_W-1:0] chain_reg;
  logic tick_reg;
  logic inst_pulse;

  assign inst_pulse = (inst_cnt_reg == `RIT_INST_LAST);

  // halting clears the whole chain so a restart divides from zero
  always_ff @(posedge clk) begin
    if (reset || pre.halt) begin
      inst_cnt_reg <= `RIT_INST_ZERO;
    end else if (inst_pulse) begin
      inst_cnt_reg <= `RIT_INST_ZERO;
    end else begin
      inst_cnt_reg <= inst_cnt_reg + `RIT_INST_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || pre.halt) begin
      chain_reg <= `RIT_CHAIN_ZERO;
    end else if (inst_pulse) begin
      chain_reg <= chain_reg + `RIT_CHAIN_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= !pre.halt && inst_pulse && ((chain_reg & MASK) == MASK);
    end
  end

  assign pre.tick = tick_reg;
  assign pre.sio_tick = tick_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chain_cleared_a: assert property (pre.halt |=> chain_reg == `RIT_CHAIN_ZERO
    && inst_cnt_reg == `RIT_INST_ZERO)
    else $error("prescaler chain not cleared while halted");
  tick_spacing_a: assert property (tick_reg |=> !tick_reg [*5])
    else $error("ticks closer than one instruction period");
  halt_no_tick_a: assert property (pre.halt |=> !tick_reg)
    else $error("tick produced while prescaler halted");

endmodule : rit_prescaler

`default_nettype wire

/* File: design/rit_timer.sv */
/*
  Reload interval timer: 8-bit up counter with single and repeat modes,
  overflow flag, interrupt request and 4-bit peripheral register access.
  Assumes one CPU access per cycle, selected by the Y' pointer, with the
  Y pointer LSB choosing the nibble, and an interrupt enable from outside.
*/
// Behaviour
// - 8-bit up counter advancing only on prescaler ticks, never from pins.
// - rollover at FF with timer interrupt enabled raises an interrupt request.
// - repeat mode reloads the counter on every rollover and keeps counting.
// - single mode stops the counter at rollover until software starts it again.
// - writing 1 to control bit 0 loads the latest reload value and starts.
// - overflow flag sets on rollover only while the interrupt is enabled.
// - overflow flag clears on reset and on a timer start, unless an enabled rollover falls in the start cycle.
// - tick is the instruction rate (clock over 6) over a power of two.
// - halted prescaler freezes the counter, which resumes from the kept count.
// - restarting the prescaler clears its divider chain to zero.
// - prescaler also feeds the serial shift clock, which stops with it.
// - nibble writes to the reload register pick high or low by Y LSB.
// - nibble reads return the live counter's high or low half by Y LSB.
// - counter is not latched between nibble reads, halves may mismatch.
// - control bit 2 high halts the prescaler, low lets it run.
`timescale 1ns/1ns
`default_nettype none
`include "rit_consts.svh"

module rit_timer #(
  parameter int DIV_LOG2 = `RIT_DIV_LOG2_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] per_sel,
  input wire logic y_lsb,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [3:0] wr_data,
  input wire logic timer_irq_en,
  output logic [3:0] rd_data,
  output logic rd_valid,
  output logic irq_req,
  output logic sio_clk_tick
);

  function automatic logic sel_hit(input logic [3:0] sel, input logic [3:0] code);
    sel_hit = (sel == code);
  endfunction : sel_hit

  rit_pre_if pre_link ();

  rit_prescaler #(
    .DIV_LOG2(DIV_LOG2)
  ) u_pre (
    .clk(clk),
    .reset(reset),
    .pre(pre_link.gen)
  );

  rit_pkg::rit_state_e state_reg;
  rit_pkg::rit_count_t count_reg;
  rit_pkg::rit_count_t reload_reg;
  logic repeat_reg;
  logic halt_reg;
  logic flag_reg;
  logic [3:0] rd_data_reg;
  logic rd_valid_reg;
  logic irq_req_reg;
  logic sio_tick_reg;

  logic wr_ctrl;
  logic wr_reload;
  logic rd_ctrl;
  logic rd_count;
  logic start;
  logic tick_ok;
  logic rollover;
  logic flag_set;

  assign wr_ctrl = wr_stb && sel_hit(per_sel, `RIT_SEL_CTRL);
  assign wr_reload = wr_stb && sel_hit(per_sel, `RIT_SEL_RELOAD);
  assign rd_ctrl = rd_stb && sel_hit(per_sel, `RIT_SEL_CTRL);
  assign rd_count = rd_stb && sel_hit(per_sel, `RIT_SEL_RELOAD);
  assign start = wr_ctrl && wr_data[`RIT_CTRL_START];

  // only the internal prescaler tick advances the counter
  assign tick_ok = pre_link.tick && !halt_reg && (state_reg == rit_pkg::RIT_ST_COUNT);
  assign rollover = tick_ok && (count_reg == `RIT_CNT_MAX);
  assign flag_set = rollover && timer_irq_en;

  assign pre_link.halt = halt_reg;

  // control bits: mode and prescaler halt
  always_ff @(posedge clk) begin
    if (reset) begin
      repeat_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else if (wr_ctrl) begin
      repeat_reg <= wr_data[`RIT_CTRL_REPEAT];
      halt_reg <= wr_data[`RIT_CTRL_HALT];
    end
  end

  // reload value, written a nibble at a time
  always_ff @(posedge clk) begin
    if (reset) begin
      reload_reg <= `RIT_CNT_ZERO;
    end else if (wr_reload) begin
      if (y_lsb) begin
        reload_reg[7:4] <= wr_data;
      end else begin
        reload_reg[3:0] <= wr_data;
      end
    end
  end

  // run state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= rit_pkg::RIT_ST_IDLE;
    end else begin
      case (state_reg)
        rit_pkg::RIT_ST_IDLE: begin
          if (start) begin
            state_reg <= rit_pkg::RIT_ST_COUNT;
          end
        end
        rit_pkg::RIT_ST_COUNT: begin
          if (!start && rollover && !repeat_reg) begin
            state_reg <= rit_pkg::RIT_ST_IDLE;
          end
        end
        default: begin
          state_reg <= rit_pkg::RIT_ST_IDLE;
        end
      endcase
    end
  end

  // counter
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= `RIT_CNT_ZERO;
    end else if (start) begin
      count_reg <= reload_reg;
    end else if (rollover) begin
      count_reg <= repeat_reg ? reload_reg : `RIT_CNT_ZERO;
    end else if (tick_ok) begin
      count_reg <= count_reg + `RIT_CNT_ONE;
    end
  end

  // overflow flag: an enabled rollover in the start cycle still sets it
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (start) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= flag_set;
    end
  end

  // reads: live counter, no snapshot between the two halves
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= `RIT_NIB_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_ctrl || rd_count;
      if (rd_ctrl) begin
        rd_data_reg <= {flag_reg, halt_reg, repeat_reg, 1'b0};
      end else if (rd_count) begin
        rd_data_reg <= y_lsb ? count_reg[7:4] : count_reg[3:0];
      end else begin
        rd_data_reg <= `RIT_NIB_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sio_tick_reg <= 1'b0;
    end else begin
      sio_tick_reg <= pre_link.sio_tick;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign irq_req = irq_req_reg;
  assign sio_clk_tick = sio_tick_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  count_step_a: assert property (
    tick_ok && !start && count_reg != `RIT_CNT_MAX |=> count_reg == $past(count_reg) + `RIT_CNT_ONE)
    else $error("counter did not advance by one on a tick");
  count_no_tick_a: assert property (
    !pre_link.tick && !start |=> count_reg == $past(count_reg))
    else $error("counter moved without a prescaler tick");
  irq_rollover_a: assert property (
    rollover && timer_irq_en |=> irq_req && flag_reg)
    else $error("rollover with interrupt enabled gave no request");
  irq_cause_a: assert property (
    irq_req |-> $past(rollover) && $past(timer_irq_en))
    else $error("interrupt request without an enabled rollover");
  repeat_reload_a: assert property (
    rollover && repeat_reg && !start
    |=> count_reg == $past(reload_reg) && state_reg == rit_pkg::RIT_ST_COUNT)
    else $error("repeat mode did not reload and keep counting");
  single_stop_a: assert property (
    rollover && !repeat_reg && !start
    |=> state_reg == rit_pkg::RIT_ST_IDLE && count_reg == `RIT_CNT_ZERO)
    else $error("single mode did not stop at rollover");
  idle_hold_a: assert property (
    state_reg == rit_pkg::RIT_ST_IDLE && !start |=> $stable(count_reg))
    else $error("stopped counter changed without a start");
  start_load_a: assert property (
    start |=> count_reg == $past(reload_reg) && state_reg == rit_pkg::RIT_ST_COUNT)
    else $error("start did not load reload value and run");
  flag_gate_a: assert property (
    rollover && !timer_irq_en && !start |=> flag_reg == $past(flag_reg))
    else $error("flag changed on rollover with interrupt disabled");
  flag_clear_a: assert property (
    start && !flag_set |=> !flag_reg)
    else $error("flag not cleared by a start");
  halt_freeze_a: assert property (
    halt_reg && !start |=> $stable(count_reg))
    else $error("counter moved while prescaler halted");
  sio_halt_a: assert property (
    halt_reg [*2] |=> !sio_clk_tick)
    else $error("serial tick while prescaler halted");
  reload_write_a: assert property (
    wr_reload && y_lsb |=> reload_reg[7:4] == $past(wr_data)
    && reload_reg[3:0] == $past(reload_reg[3:0]))
    else $error("upper nibble write to reload value wrong");
  count_read_a: assert property (
    rd_count && !y_lsb |=> rd_valid && rd_data == $past(count_reg[3:0]))
    else $error("lower nibble read of counter wrong");
  halt_bit_a: assert property (
    wr_ctrl |=> halt_reg == $past(wr_data[`RIT_CTRL_HALT])
    && repeat_reg == $past(wr_data[`RIT_CTRL_REPEAT]))
    else $error("control write did not set halt and mode bits");
  ctrl_read_a: assert property (
    rd_ctrl |=> rd_data == {$past(flag_reg), $past(halt_reg), $past(repeat_reg), 1'b0})
    else $error("control read back wrong");

  // other nibble halves, refused accesses, pulse shapes, flag life and repeat run
  reload_low_a: assert property (
    wr_reload && !y_lsb |=> reload_reg[3:0] == $past(wr_data)
    && reload_reg[7:4] == $past(reload_reg[7:4]))
    else $error("lower nibble write to reload value wrong");
  count_read_hi_a: assert property (
    rd_count && y_lsb |=> rd_valid && rd_data == $past(count_reg[7:4]))
    else $error("upper nibble read of counter wrong");
  read_refused_a: assert property (
    !rd_ctrl && !rd_count |=> !rd_valid && rd_data == `RIT_NIB_ZERO)
    else $error("read answered outside the mapped registers");
  read_cause_a: assert property (
    rd_valid |-> $past(rd_ctrl) || $past(rd_count))
    else $error("read valid without a mapped read");
  write_refused_a: assert property (
    !wr_ctrl && !wr_reload |=> $stable(reload_reg) && $stable(halt_reg) && $stable(repeat_reg))
    else $error("write changed registers outside the mapped selects");
  irq_pulse_a: assert property (
    irq_req |=> !irq_req)
    else $error("interrupt request longer than one cycle");
  irq_disabled_a: assert property (
    !timer_irq_en |=> !irq_req)
    else $error("interrupt request while interrupt disabled");
  flag_set_a: assert property (
    flag_set |=> flag_reg)
    else $error("overflow flag not set by an enabled rollover");
  flag_hold_a: assert property (
    flag_reg && !start |=> flag_reg)
    else $error("overflow flag lost without a start");
  repeat_run_a: assert property (
    state_reg == rit_pkg::RIT_ST_COUNT && repeat_reg |=> state_reg == rit_pkg::RIT_ST_COUNT)
    else $error("repeat mode stopped counting");
  sio_pulse_a: assert property (
    sio_clk_tick |=> !sio_clk_tick)
    else $error("serial tick longer than one cycle");

  // main scenarios
  repeat_roll_c: cover property (rollover && repeat_reg);
  single_roll_c: cover property (rollover && !repeat_reg ##1 state_reg == rit_pkg::RIT_ST_IDLE);
  disabled_roll_c: cover property (rollover && !timer_irq_en);
  halt_resume_c: cover property (halt_reg && state_reg == rit_pkg::RIT_ST_COUNT ##1 !halt_reg);
  split_read_c: cover property (rd_count && !y_lsb ##1 tick_ok ##1 rd_count && y_lsb);

endmodule : rit_timer

`default_nettype wire

/* File: sim/tb_reload_interval_timer.sv */
/*
  Self-checking bench for the reload interval timer: nibble register
  accesses, halt and release of the prescaler, single and repeat modes.
  Assumes rit_timer, rit_prescaler, rit_pre_if and rit_consts.svh are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rit_consts.svh"

module tb_reload_interval_timer;
  logic clk, reset, y_lsb, wr_stb, rd_stb, timer_irq_en;
  logic rd_valid, irq_req, sio_clk_tick, vld;
  logic [3:0] per_sel, wr_data, rd_data, nib;
  int mismatches = 0;
  int n_tests = 0;
  int n_irq = 0;
  int n_sio = 0;
  int cyc, base;

  rit_timer #(.DIV_LOG2(1)) u_dut (
    .clk(clk), .reset(reset), .per_sel(per_sel), .y_lsb(y_lsb), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wr_data(wr_data), .timer_irq_en(timer_irq_en), .rd_data(rd_data),
    .rd_valid(rd_valid), .irq_req(irq_req), .sio_clk_tick(sio_clk_tick)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulse counters for interrupt requests and shift ticks
  always @(posedge clk) begin
    if (irq_req === 1'b1) n_irq <= n_irq + 1;
    if (sio_clk_tick === 1'b1) n_sio <= n_sio + 1;
  end

  task finish_test;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  task chk_nib(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_nib

  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task chk_int(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_int

  task wr(input logic [3:0] sel, input logic y, input logic [3:0] d);
    @(posedge clk);
    #1;
    per_sel = sel;
    y_lsb = y;
    wr_data = d;
    wr_stb = 1'b1;
    @(posedge clk);
    #1;
    wr_stb = 1'b0;
  endtask : wr

  // read one nibble and compare data and valid
  task rdc(input logic [3:0] sel, input logic y, input logic [3:0] exp);
    @(posedge clk);
    #1;
    per_sel = sel;
    y_lsb = y;
    rd_stb = 1'b1;
    @(posedge clk);
    #1;
    rd_stb = 1'b0;
    nib = rd_data;
    vld = rd_valid;
    chk_bit(vld, (sel == `RIT_SEL_CTRL) || (sel == `RIT_SEL_RELOAD));
    chk_nib(nib, exp);
  endtask : rdc

  task wait_sio;
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (sio_clk_tick !== 1'b1 && cyc < 100);
  endtask : wait_sio

  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test;
  end

  initial begin
    reset = 1'b1;
    per_sel = 4'h0;
    y_lsb = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = 4'h0;
    timer_irq_en = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    rdc(`RIT_SEL_CTRL, 1'b0, 4'h0);
    rdc(`RIT_SEL_RELOAD, 1'b1, 4'h0);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'h0);
    rdc(4'h5, 1'b0, 4'h0);
    // load 5A while halted, then release
    wr(`RIT_SEL_RELOAD, 1'b1, 4'h5);
    wr(`RIT_SEL_RELOAD, 1'b0, 4'hA);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h4);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h5);
    rdc(`RIT_SEL_RELOAD, 1'b1, 4'h5);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'hA);
    rdc(`RIT_SEL_CTRL, 1'b0, 4'h4);
    base = n_sio;
    idle(40);
    chk_int(n_sio, base, base);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'hA);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h0);
    wait_sio;
    chk_int(cyc, 12, 15);
    wait_sio;
    chk_int(cyc, 12, 12);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'hC);
    rdc(`RIT_SEL_RELOAD, 1'b1, 4'h5);
    // single mode from FD with interrupt enabled
    base = n_irq;
    wr(`RIT_SEL_RELOAD, 1'b1, 4'hF);
    wr(`RIT_SEL_RELOAD, 1'b0, 4'hD);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h0);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h1);
    cyc = 0;
    while (n_irq == base && cyc < 100) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    chk_int(cyc, 24, 40);
    chk_int(n_irq - base, 1, 1);
    rdc(`RIT_SEL_CTRL, 1'b0, 4'h8);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'h0);
    rdc(`RIT_SEL_RELOAD, 1'b1, 4'h0);
    idle(60);
    chk_int(n_irq - base, 1, 1);
    rdc(`RIT_SEL_RELOAD, 1'b0, 4'h0);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h1);
    rdc(`RIT_SEL_CTRL, 1'b0, 4'h0);
    // repeat mode from FE: one enabled rollover, then interrupt disabled
    base = n_irq;
    wr(`RIT_SEL_RELOAD, 1'b1, 4'hF);
    wr(`RIT_SEL_RELOAD, 1'b0, 4'hE);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h2);
    wr(`RIT_SEL_CTRL, 1'b0, 4'h3);
    cyc = 0;
    while (n_irq == base && cyc < 100) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    timer_irq_en = 1'b0;
    idle(150);
    chk_int(n_irq - base, 1, 1);
    rdc(`RIT_SEL_RELOAD, 1'b1, 4'hF);
    rdc(`RIT_SEL_CTRL, 1'b0, 4'hA);
    finish_test;
  end
endmodule : tb_reload_interval_timer

`default_nettype wire
